// *** core/pfcr_regs.sv ***
// Register bank of the pump fieldbus control interface
`timescale 1ns/10ps
// How it works
// [RULE1] Holding registers are 16-bit commands the PLC writes, 4x space.
// [RULE2] Input registers are 16-bit status the pump supplies, 3x space.
// [RULE3] Packed speed: whole percent in upper byte, hundredths in lower.
// [RULE4] Word speed: one unsigned value, percent times one hundred.
// [RULE5] Direction 0x00 is clockwise, 0x01 counter-clockwise.
// [RULE6] Run command bits: 0 prime, 1 start, 2 stop; one activates.
// [RULE7] Packed holding 1: direction low byte, run bits high byte.
// [RULE8] Alarm reset clears tube and flow alarms on a 0 to 1 change.
// [RULE9] Packed holding 2: alarm reset low byte, tube reset high byte.
// [RULE10] Tube statistics reset clears revolution counter and hours.
// [RULE11] Debug counter direction 0 counts up, 1 counts down.
// [RULE12] Debug rate 0 holds counter; N steps it once every N cycles.
// [RULE13] Packed holding 3: counter direction low, counter rate high.
// [RULE14] Input 0: run status bits low byte, cover state high byte.
// [RULE15] Input 1: actual direction low byte, tube fault alarm high.
// [RULE16] Input 2: flow alarm low byte, relay flags bits 0,1,3,4 high.
// [RULE17] Input 3: loop current mA high byte, hundredths low byte.
// [RULE18] Input 4: frequency as digit pairs, thousands/hundreds high.
// [RULE19] Input 6: build channel low byte, patch number high byte.
// [RULE20] Input 7: firmware major high byte, minor low byte.
// [RULE21] Revolutions at inputs 8 and 9, hours at inputs 10 and 11.
// [RULE22] Input 12 reports the debug cyclic counter value.
// [RULE23] Tube statistics reset acts on a zero to nonzero change.
// [RULE24] Undefined status bits read zero; PLC writes undefined as zero.
module pfcr_regs
   import pfcr_pkg::*;
#(
   parameter int          STAT_WIDTH = 32,
   parameter logic [7:0]  FW_MAJOR   = 8'h01,  // Arbitrary value
   parameter logic [7:0]  FW_MINOR   = 8'h00,  // Arbitrary value
   parameter logic [7:0]  FW_PATCH   = 8'h00,  // Arbitrary value
   parameter logic [7:0]  FW_CHANNEL = 8'h00   // Arbitrary value
) (
   input  wire logic          sys_clk,
   input  wire logic          srst,
   input  wire pfcr_layout_e  layoutSel,
   input  wire logic          wrEn,
   input  wire logic [3:0]    wrAddr,
   input  wire logic [15:0]   wrData,
   input  wire logic          rdEn,
   input  wire logic [3:0]    rdAddr,
   output logic [15:0]        rdData_q,
   output logic               rdValid_q,
   input  wire pfcr_status_s  pumpStatus,
   input  wire logic          tubeRevTick,
   input  wire logic          tubeHourTick,
   output pfcr_cmd_s          pumpCmd_q,
   output logic               tubeFaultAlarm_q,
   output logic               flowVerificationAlarm_q
);

   // Elaboration check: readout splits the counters into two 16-bit words
   if (STAT_WIDTH < 17 || STAT_WIDTH > 32) begin : g_bad_width
      $error("STAT_WIDTH must be 17..32");
   end

   // ----------------------------------------------------------------------
   // Holding registers
   // ----------------------------------------------------------------------
   logic [7:0]            alarmCmd_q;
   logic [7:0]            tubeCmd_q;
   logic                  dbgDown_q;
   logic [7:0]            dbgRate_q;
   logic [15:0]           dbgCount_q;
   logic [7:0]            dbgDiv_q;
   logic [STAT_WIDTH-1:0] tubeRevs_q;
   logic [STAT_WIDTH-1:0] tubeHours_q;
   logic                  alarmPulse;
   logic                  tubePulse;
   logic [7:0]            newAlarm;
   logic [7:0]            newTube;
   logic                  alarmWr;
   logic                  tubeWr;

   // Packed percent converted to hundredths so the pump sees one format
   function automatic logic [15:0] packedToHundredths(input logic [15:0] v);
      logic [15:0] whole;
      logic [15:0] frac;
      whole = {8'h00, v[15:8]};
      frac  = {8'h00, v[7:0]};
      return 16'((whole * 16'h0064) + frac);
   endfunction

   always_comb begin
      alarmWr  = 1'b0;
      tubeWr   = 1'b0;
      newAlarm = alarmCmd_q;
      newTube  = tubeCmd_q;
      if (wrEn && layoutSel == PFCR_LAYOUT_PACKED
          && wrAddr == HR_ALARM_TUBE) begin
         alarmWr  = 1'b1;                                         // [RULE9]
         tubeWr   = 1'b1;
         newAlarm = wrData[7:0];
         newTube  = wrData[15:8];
      end else if (wrEn && layoutSel == PFCR_LAYOUT_WORD) begin
         if (wrAddr == HW_ALARM) begin
            alarmWr  = 1'b1;
            newAlarm = (wrData == WORD_ZERO) ? BYTE_ZERO : CMD_ACTIVE;
         end
         if (wrAddr == HW_TUBE) begin
            tubeWr  = 1'b1;
            newTube = (wrData == WORD_ZERO) ? BYTE_ZERO : CMD_ACTIVE;
         end
      end
      alarmPulse = alarmWr && alarmCmd_q == BYTE_ZERO
                   && newAlarm == CMD_ACTIVE;                     // [RULE8]
      tubePulse  = tubeWr && tubeCmd_q == BYTE_ZERO
                   && newTube != BYTE_ZERO;                       // [RULE23]
   end

   // Command word: every field in one process, so the port has one driver
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pumpCmd_q <= '0;
      end else begin
         pumpCmd_q.alarmClr <= alarmPulse;
         pumpCmd_q.tubeClr  <= tubePulse;
         if (wrEn && layoutSel == PFCR_LAYOUT_PACKED) begin       // [RULE1]
            if (wrAddr == HR_SPEED)
               pumpCmd_q.speed <= packedToHundredths(wrData);     // [RULE3]
            if (wrAddr == HR_DIR_RUN) begin                       // [RULE7]
               pumpCmd_q.dirCcw <= (wrData[7:0] == DIR_CCW);      // [RULE5]
               pumpCmd_q.runCmd <= wrData[10:8] & RUN_BITS_MASK;  // [RULE6]
            end
         end else if (wrEn) begin
            if (wrAddr == HW_SPEED)
               pumpCmd_q.speed <= wrData;                         // [RULE4]
            if (wrAddr == HW_DIR)
               pumpCmd_q.dirCcw <= (wrData[7:0] == DIR_CCW);      // [RULE5]
            if (wrAddr == HW_RUN)
               pumpCmd_q.runCmd <= wrData[2:0] & RUN_BITS_MASK;   // [RULE6]
         end
      end
   end

   // Reset commands: last written values kept for edge detection
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         alarmCmd_q <= BYTE_ZERO;
         tubeCmd_q  <= BYTE_ZERO;
      end else begin
         if (alarmWr)
            alarmCmd_q <= newAlarm;
         if (tubeWr)
            tubeCmd_q <= newTube;
      end
   end

   // ----------------------------------------------------------------------
   // Alarms: a raised alarm wins over a clear in the same cycle
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tubeFaultAlarm_q        <= 1'b0;
         flowVerificationAlarm_q <= 1'b0;
      end else begin
         if (pumpStatus.tubeFaultAlarm)
            tubeFaultAlarm_q <= 1'b1;
         else if (alarmPulse)
            tubeFaultAlarm_q <= 1'b0;                             // [RULE8]
         if (pumpStatus.flowVerificationAlarm)
            flowVerificationAlarm_q <= 1'b1;
         else if (alarmPulse)
            flowVerificationAlarm_q <= 1'b0;                      // [RULE8]
      end
   end

   // ----------------------------------------------------------------------
   // Tube statistics; a tick in the clear cycle is counted from zero
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tubeRevs_q  <= STAT_WIDTH'(STAT_ZERO);
         tubeHours_q <= STAT_WIDTH'(STAT_ZERO);
      end else if (tubePulse) begin                               // [RULE10]
         tubeRevs_q  <= STAT_WIDTH'(tubeRevTick);
         tubeHours_q <= STAT_WIDTH'(tubeHourTick);
      end else begin
         tubeRevs_q  <= tubeRevs_q + STAT_WIDTH'(tubeRevTick);
         tubeHours_q <= tubeHours_q + STAT_WIDTH'(tubeHourTick);
      end
   end

   // ----------------------------------------------------------------------
   // Debug cyclic counter
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dbgDown_q <= 1'b0;
         dbgRate_q <= BYTE_ZERO;
      end else if (wrEn) begin
         if (layoutSel == PFCR_LAYOUT_PACKED) begin
            if (wrAddr == HR_DBG_SETUP) begin                     // [RULE13]
               dbgDown_q <= wrData[0];
               dbgRate_q <= wrData[15:8];
            end
         end else begin
            if (wrAddr == HW_DBG_DIR)
               dbgDown_q <= wrData[0];
            if (wrAddr == HW_DBG_RATE)
               dbgRate_q <= wrData[7:0];
         end
      end
   end

   // Divider restarts when the rate is zero so a new rate counts in full
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dbgDiv_q   <= BYTE_ZERO;
         dbgCount_q <= WORD_ZERO;
      end else if (dbgRate_q == BYTE_ZERO) begin
         dbgDiv_q <= BYTE_ZERO;                                   // [RULE12]
      end else if (dbgDiv_q + 8'h01 >= dbgRate_q) begin
         dbgDiv_q <= BYTE_ZERO;
         if (dbgDown_q)
            dbgCount_q <= dbgCount_q - 16'h0001;                  // [RULE11]
         else
            dbgCount_q <= dbgCount_q + 16'h0001;
      end else begin
         dbgDiv_q <= dbgDiv_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Input register read, one cycle after rdEn
   // ----------------------------------------------------------------------
   logic [31:0] revWide;
   logic [31:0] hourWide;
   assign revWide  = 32'(tubeRevs_q);
   assign hourWide = 32'(tubeHours_q);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdData_q  <= WORD_ZERO;
         rdValid_q <= 1'b0;
      end else begin
         rdValid_q <= rdEn;                                       // [RULE2]
         if (rdEn) begin
            case (rdAddr)
               IR_RUN_COVER:                                      // [RULE14]
                  rdData_q <= {7'h00, pumpStatus.coverOpen,
                               5'h00, pumpStatus.runStatus};
               IR_DIR_TUBE:                                       // [RULE15]
                  rdData_q <= {7'h00, tubeFaultAlarm_q,
                               7'h00, pumpStatus.dirCcw};
               IR_FLOW_RELAY:                                     // [RULE16]
                  rdData_q <= {3'h0, pumpStatus.relays & RELAY_MASK,
                               7'h00, flowVerificationAlarm_q};
               IR_LOOP_CURRENT:
                  rdData_q <= pumpStatus.loopCurrent;             // [RULE17]
               IR_FREQUENCY:
                  rdData_q <= pumpStatus.frequency;               // [RULE18]
               IR_SPEED:
                  rdData_q <= pumpStatus.speedReport;             // [RULE3]
               IR_FW_PATCH:
                  rdData_q <= {FW_PATCH, FW_CHANNEL};             // [RULE19]
               IR_FW_MAJMIN:
                  rdData_q <= {FW_MAJOR, FW_MINOR};               // [RULE20]
               IR_REV_HI:   rdData_q <= revWide[31:16];           // [RULE21]
               IR_REV_LO:   rdData_q <= revWide[15:0];
               IR_HOURS_HI: rdData_q <= hourWide[31:16];
               IR_HOURS_LO: rdData_q <= hourWide[15:0];
               IR_DBG_COUNT:
                  rdData_q <= dbgCount_q;                         // [RULE22]
               default:
                  rdData_q <= WORD_ZERO;                          // [RULE24]
            endcase
         end
      end
   end

endmodule // pfcr_regs

// *** pkg/pfcr_pkg.sv ***
// Package for the pump fieldbus control register bank: map, fields, types
package pfcr_pkg;

   // ----------------------------------------------------------------------
   // Register indices (16-bit words)
   // ----------------------------------------------------------------------
   localparam logic [3:0] HR_SPEED        = 4'h0;
   localparam logic [3:0] HR_DIR_RUN      = 4'h1;
   localparam logic [3:0] HR_ALARM_TUBE   = 4'h2;
   localparam logic [3:0] HR_DBG_SETUP    = 4'h3;
   // Word layout holding registers
   localparam logic [3:0] HW_SPEED        = 4'h0;
   localparam logic [3:0] HW_DIR          = 4'h1;
   localparam logic [3:0] HW_RUN          = 4'h2;
   localparam logic [3:0] HW_ALARM        = 4'h3;
   localparam logic [3:0] HW_TUBE         = 4'h4;
   localparam logic [3:0] HW_DBG_DIR      = 4'h5;
   localparam logic [3:0] HW_DBG_RATE     = 4'h6;
   // Input registers
   localparam logic [3:0] IR_RUN_COVER    = 4'h0;
   localparam logic [3:0] IR_DIR_TUBE     = 4'h1;
   localparam logic [3:0] IR_FLOW_RELAY   = 4'h2;
   localparam logic [3:0] IR_LOOP_CURRENT = 4'h3;
   localparam logic [3:0] IR_FREQUENCY    = 4'h4;
   localparam logic [3:0] IR_SPEED        = 4'h5;
   localparam logic [3:0] IR_FW_PATCH     = 4'h6;
   localparam logic [3:0] IR_FW_MAJMIN    = 4'h7;
   localparam logic [3:0] IR_REV_HI       = 4'h8;
   localparam logic [3:0] IR_REV_LO       = 4'h9;
   localparam logic [3:0] IR_HOURS_HI     = 4'hA;
   localparam logic [3:0] IR_HOURS_LO     = 4'hB;
   localparam logic [3:0] IR_DBG_COUNT    = 4'hC;

   // ----------------------------------------------------------------------
   // Field values and reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0]  DIR_CW        = 8'h00;
   localparam logic [7:0]  DIR_CCW       = 8'h01;
   localparam logic [7:0]  CMD_ACTIVE    = 8'h01;
   localparam int          RUN_PRIME_BIT = 0;
   localparam int          RUN_START_BIT = 1;
   localparam int          RUN_STOP_BIT  = 2;
   localparam logic [15:0] WORD_ZERO     = 16'h0000;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [2:0]  RUN_BITS_MASK = 3'h7;
   localparam logic [4:0]  RELAY_MASK    = 5'h1B;
   localparam logic [31:0] STAT_ZERO     = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic {
      PFCR_LAYOUT_PACKED,
      PFCR_LAYOUT_WORD
   } pfcr_layout_e;

   typedef struct packed {
      logic [15:0] speed;     // Hundredths of a percent, binary
      logic        dirCcw;
      logic [2:0]  runCmd;    // Prime, start, stop request levels
      logic        alarmClr;  // One-cycle pulse
      logic        tubeClr;   // One-cycle pulse
   } pfcr_cmd_s;

   typedef struct packed {
      logic [2:0]  runStatus;
      logic        coverOpen;
      logic        dirCcw;
      logic        tubeFaultAlarm;
      logic        flowVerificationAlarm;
      logic [4:0]  relays;
      logic [15:0] loopCurrent;   // Packed: mA in high byte
      logic [15:0] frequency;     // Packed decimal digit pairs
      logic [15:0] speedReport;   // Packed: percent in high byte
   } pfcr_status_s;

endpackage : pfcr_pkg

// *** sim/pfcr_regs_assertions.sv ***
// Concurrent checks on the pump fieldbus register bank ports
`timescale 1ns/10ps
module pfcr_regs_assertions
   import pfcr_pkg::*;
#(
   parameter logic [7:0] FW_MAJOR = 8'h01,
   parameter logic [7:0] FW_MINOR = 8'h00
) (
   input wire logic         sys_clk,
   input wire logic         srst,
   input wire pfcr_layout_e layoutSel,
   input wire logic         wrEn,
   input wire logic [3:0]   wrAddr,
   input wire logic [15:0]  wrData,
   input wire logic         rdEn,
   input wire logic [3:0]   rdAddr,
   input wire logic [15:0]  rdData_q,
   input wire logic         rdValid_q,
   input wire pfcr_status_s pumpStatus,
   input wire pfcr_cmd_s    pumpCmd_q,
   input wire logic         tubeFaultAlarm_q,
   input wire logic         flowVerificationAlarm_q
);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic pk;
   assign pk = (layoutSel == PFCR_LAYOUT_PACKED);
   sequence s_pwr(a);
      pk && wrEn && wrAddr == a;
   endsequence
   // Raise wins over clear, so only a clear with no raise is judged
   sequence s_clr;
      pumpCmd_q.alarmClr && !$past(pumpStatus.tubeFaultAlarm)
         && !$past(pumpStatus.flowVerificationAlarm);
   endsequence
   a_read_valid: assert property (rdEn |=> rdValid_q)
      else $error("read strobe not answered");
   a_packed_speed: assert property (s_pwr(HR_SPEED) |=>
      pumpCmd_q.speed == 16'($past(wrData[15:8])) * 16'h0064
      + 16'($past(wrData[7:0])))
      else $error("packed speed wrong");
   a_word_speed: assert property (!pk && wrEn && wrAddr == HW_SPEED
      |=> pumpCmd_q.speed == $past(wrData))
      else $error("word speed wrong");
   a_dir_run: assert property (s_pwr(HR_DIR_RUN) |=>
      pumpCmd_q.dirCcw == ($past(wrData[7:0]) == DIR_CCW)
      && pumpCmd_q.runCmd == $past(wrData[10:8]))
      else $error("direction or run command wrong");
   a_cmd_hold: assert property (!wrEn |=> $stable(pumpCmd_q.speed))
      else $error("speed changed without write");
   a_clr_pulse: assert property (pumpCmd_q.alarmClr |=>
      !pumpCmd_q.alarmClr)
      else $error("alarm clear longer than one cycle");
   a_clr_cause: assert property (pumpCmd_q.alarmClr |->
      $past(wrEn) || $past(wrEn, 2))
      else $error("alarm clear without write");
   a_alarm_clear: assert property (s_clr |->
      !tubeFaultAlarm_q && !flowVerificationAlarm_q)
      else $error("alarms not cleared");
   a_alarm_raise: assert property ($rose(tubeFaultAlarm_q) |->
      $past(pumpStatus.tubeFaultAlarm))
      else $error("tube alarm set without cause");
   a_stat_cause: assert property (pumpCmd_q.tubeClr |->
      $past(wrEn) || $past(wrEn, 2))
      else $error("tube clear without write");
   a_fw_read: assert property (rdEn && rdAddr == IR_FW_MAJMIN |=>
      rdData_q == {FW_MAJOR, FW_MINOR})
      else $error("firmware version read wrong");
   a_undef_zero: assert property (rdEn && rdAddr > IR_DBG_COUNT |=>
      rdData_q == WORD_ZERO)
      else $error("unmapped read not zero");
endmodule // pfcr_regs_assertions

bind pfcr_regs pfcr_regs_assertions #(.FW_MAJOR(FW_MAJOR),
   .FW_MINOR(FW_MINOR)) chk_u (.sys_clk, .srst, .layoutSel, .wrEn, .wrAddr,
   .wrData, .rdEn, .rdAddr, .rdData_q, .rdValid_q, .pumpStatus, .pumpCmd_q,
   .tubeFaultAlarm_q, .flowVerificationAlarm_q);

// *** sim/pfcr_plc_model.sv ***
// Model of the remote PLC: writes holding words, reads input words
`timescale 1ns/10ps
module pfcr_plc_model (
   input  wire logic        sys_clk,
   output logic             wrEn,
   output logic [3:0]       wrAddr,
   output logic [15:0]      wrData,
   output logic             rdEn,
   output logic [3:0]       rdAddr,
   input  wire logic [15:0] rdData_q,
   input  wire logic        rdValid_q
);
   initial begin
      {wrEn, wrAddr, wrData, rdEn, rdAddr} = '0;
   end
   // Whole 16-bit words only; undefined bits are left zero by callers
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk); #1;
      {wrEn, wrAddr, wrData} = {1'b1, a, d};
      @(posedge sys_clk); #1;
      // Released bus shows garbage, never the old word
      {wrEn, wrAddr, wrData} = {1'b0, ~a, ~d};
   endtask
   // Input words are only read, never written
   task automatic rd(input logic [3:0] a, output logic [15:0] d,
                     output logic v);
      @(posedge sys_clk); #1;
      {rdEn, rdAddr} = {1'b1, a};
      @(posedge sys_clk); #1;
      {rdEn, rdAddr} = {1'b0, ~a};
      v = rdValid_q;
      d = rdData_q;
   endtask
endmodule // pfcr_plc_model

// *** sim/pfcr_regs_tb.sv ***
// Self-checking bench for the pump fieldbus register bank
`timescale 1ns/10ps
module pfcr_regs_tb;
   import pfcr_pkg::*;
   logic         sys_clk, srst, wrEn, rdEn, rdValid_q;
   logic         tubeRevTick, tubeHourTick;
   logic         tubeFaultAlarm_q, flowVerificationAlarm_q;
   logic [3:0]   wrAddr, rdAddr;
   logic [15:0]  wrData, rdData_q;
   pfcr_layout_e layoutSel;
   pfcr_status_s pumpStatus;
   pfcr_cmd_s    pumpCmd_q;
   int           error_cnt = 0;
   int           n_tests = 0;

   pfcr_regs #(.FW_MAJOR(8'h02), .FW_MINOR(8'h03), .FW_PATCH(8'h05),
      .FW_CHANNEL(8'h62)) dut_u (.sys_clk, .srst, .layoutSel, .wrEn,
      .wrAddr, .wrData, .rdEn, .rdAddr, .rdData_q, .rdValid_q, .pumpStatus,
      .tubeRevTick, .tubeHourTick, .pumpCmd_q, .tubeFaultAlarm_q,
      .flowVerificationAlarm_q);
   pfcr_plc_model plc_u (.sys_clk, .wrEn, .wrAddr, .wrData, .rdEn,
      .rdAddr, .rdData_q, .rdValid_q);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic        v;
      plc_u.rd(a, d, v);
      chk("rdValid_q", 32'(v), 32'h1);
      chk("rdData_q", 32'(d), 32'(e));
   endtask
   task automatic pulse(input logic alm, rev, hr);
      @(posedge sys_clk); #1;
      {pumpStatus.tubeFaultAlarm, pumpStatus.flowVerificationAlarm} = {2{alm}};
      {tubeRevTick, tubeHourTick} = {rev, hr};
      @(posedge sys_clk); #1;
      {pumpStatus.tubeFaultAlarm, pumpStatus.flowVerificationAlarm} = 2'h0;
      {tubeRevTick, tubeHourTick} = 2'h0;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_speed();
      plc_u.wr(HR_SPEED, 16'h320F);
      chk("speed", 32'(pumpCmd_q.speed), 32'h0000_1397);
      plc_u.wr(HR_SPEED, 16'h6400);
      chk("speed", 32'(pumpCmd_q.speed), 32'h0000_2710);
      layoutSel = PFCR_LAYOUT_WORD;
      plc_u.wr(HW_SPEED, 16'h1397);
      chk("speed", 32'(pumpCmd_q.speed), 32'h0000_1397);
      plc_u.wr(HW_DIR, 16'h0001);
      chk("dirCcw", 32'(pumpCmd_q.dirCcw), 32'h1);
      plc_u.wr(HW_RUN, 16'h0004);
      chk("runCmd", 32'(pumpCmd_q.runCmd), 32'h4);
      layoutSel = PFCR_LAYOUT_PACKED;
      for (int i = 0; i < 8; i++) begin
         plc_u.wr(HR_DIR_RUN, {5'h00, 3'(i), 7'h00, i[0]});
         chk("dirCcw", 32'(pumpCmd_q.dirCcw), 32'(i[0]));
         chk("runCmd", 32'(pumpCmd_q.runCmd), 32'(i[2:0]));
      end
      $display("t_speed done");
   endtask
   task automatic t_alarm();
      pulse(1'b1, 1'b0, 1'b0);
      chk("tubeFaultAlarm_q", 32'(tubeFaultAlarm_q), 32'h1);
      rdc(IR_DIR_TUBE, 16'h0100);
      rdc(IR_FLOW_RELAY, 16'h0001);
      // Second 0x01 with no 0 between must not clear
      for (int i = 0; i < 4; i++) begin
         if (i == 2) plc_u.wr(HR_ALARM_TUBE, 16'h0000);
         plc_u.wr(HR_ALARM_TUBE, 16'h0001);
         chk("alarmClr", 32'(pumpCmd_q.alarmClr),
             (i == 0 || i == 2) ? 32'h1 : 32'h0);
         repeat (2) @(posedge sys_clk);
         chk("alarms", 32'({tubeFaultAlarm_q, flowVerificationAlarm_q}),
             (i == 1) ? 32'h3 : 32'h0);
         if (i == 0) pulse(1'b1, 1'b0, 1'b0);
      end
      // Word layout alarm reset: zero does nothing, then 0 to 1 clears
      pulse(1'b1, 1'b0, 1'b0);
      layoutSel = PFCR_LAYOUT_WORD;
      plc_u.wr(HW_ALARM, 16'h0000);
      chk("alarms", 32'({tubeFaultAlarm_q, flowVerificationAlarm_q}),
          32'h3);
      plc_u.wr(HW_ALARM, 16'h0001);
      chk("alarms", 32'({tubeFaultAlarm_q, flowVerificationAlarm_q}),
          32'h0);
      layoutSel = PFCR_LAYOUT_PACKED;
      $display("t_alarm done");
   endtask
   task automatic t_tube();
      repeat (3) pulse(1'b0, 1'b1, 1'b0);
      repeat (2) pulse(1'b0, 1'b0, 1'b1);
      rdc(IR_REV_HI, 16'h0000);
      rdc(IR_REV_LO, 16'h0003);
      rdc(IR_HOURS_HI, 16'h0000);
      rdc(IR_HOURS_LO, 16'h0002);
      plc_u.wr(HR_ALARM_TUBE, 16'h0100);
      chk("tubeClr", 32'(pumpCmd_q.tubeClr), 32'h1);
      rdc(IR_REV_LO, 16'h0000);
      rdc(IR_HOURS_LO, 16'h0000);
      pulse(1'b0, 1'b1, 1'b0);
      plc_u.wr(HR_ALARM_TUBE, 16'h0200);
      chk("tubeClr", 32'(pumpCmd_q.tubeClr), 32'h0);
      rdc(IR_REV_LO, 16'h0001);
      layoutSel = PFCR_LAYOUT_WORD;
      plc_u.wr(HW_TUBE, 16'h0000);
      plc_u.wr(HW_TUBE, 16'h0001);
      rdc(IR_REV_LO, 16'h0000);
      layoutSel = PFCR_LAYOUT_PACKED;
      $display("t_tube done");
   endtask
   task automatic t_status();
      logic [15:0] e [8] = '{16'h0105, 16'h0001, 16'h1B00, 16'h0432,
                             16'h0985, 16'h320F, 16'h0562, 16'h0203};
      pumpStatus.runStatus = 3'h5;
      {pumpStatus.coverOpen, pumpStatus.dirCcw} = 2'h3;
      pumpStatus.relays = 5'h1F;
      pumpStatus.loopCurrent = 16'h0432;
      pumpStatus.frequency = 16'h0985;
      pumpStatus.speedReport = 16'h320F;
      for (int i = 0; i < 8; i++)
         rdc(4'(i), e[i]);
      rdc(4'hD, 16'h0000);
      rdc(4'hF, 16'h0000);
      $display("t_status done");
   endtask
   task automatic t_dbg();
      logic [7:0]  rt [5] = '{8'h03, 8'h03, 8'h00, 8'h04, 8'h01};
      logic [15:0] ex [5] = '{16'h0004, 16'hFFFC, 16'h0000, 16'h0003,
                              16'hFFF4};
      logic [15:0] a, b;
      logic        v;
      for (int i = 0; i < 5; i++) begin
         layoutSel = (i < 3) ? PFCR_LAYOUT_PACKED : PFCR_LAYOUT_WORD;
         if (i < 3) plc_u.wr(HR_DBG_SETUP, {rt[i], 7'h00, i[0]});
         else begin
            plc_u.wr(HW_DBG_DIR, 16'(i[2]));
            plc_u.wr(HW_DBG_RATE, {8'h00, rt[i]});
         end
         plc_u.rd(IR_DBG_COUNT, a, v);
         repeat (10) @(posedge sys_clk);
         plc_u.rd(IR_DBG_COUNT, b, v);
         chk("counter step", 32'(16'(b - a)),
             32'(ex[i]));
      end
      $display("t_dbg done");
   endtask
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      #50000;
      error_cnt++;
      $display("ERROR watchdog expected finish seen timeout");
      end_of_test();
   end
   initial begin
      {srst, tubeRevTick, tubeHourTick} = 3'h4;
      layoutSel = PFCR_LAYOUT_PACKED;
      pumpStatus = '0;
      repeat (3) @(posedge sys_clk);
      #1 srst = 1'b0;
      chk("pumpCmd_q", 32'(pumpCmd_q), 32'h0);
      t_speed();
      t_alarm();
      t_tube();
      t_status();
      t_dbg();
      end_of_test();
   end
endmodule // pfcr_regs_tb
